//--- hw/eir_defines.svh
// Register indices, field positions, masks and reset values of the routing block
`ifndef EIR_DEFINES_SVH
`define EIR_DEFINES_SVH

// Register indices; byte address is four times the index
`define EIR_IDX_PAGE_SEL 8'h02
`define EIR_IDX_PAGE_ADDR 8'h08
`define EIR_IDX_PAGE_VALUE 8'h09
`define EIR_IDX_EMB_ROUTE 8'h0e
`define EIR_IDX_PROG_ROUTE 8'h0f
`define EIR_IDX_LEARN_ROUTE 8'h11
`define EIR_IDX_EMB_FLAGS 8'h12
`define EIR_IDX_PROG_FLAGS 8'h13
`define EIR_IDX_LEARN_FLAGS 8'h15
`define EIR_IDX_PAGE_CTRL 8'h17
`define EIR_IDX_BATCH 8'h18
`define EIR_IDX_ACK_MASK 8'h1f
`define EIR_IDX_MAIN_CFG 8'h20

// Field positions
`define EIR_BIT_LONG_COUNTER 7
`define EIR_BIT_SIG_MOTION 5
`define EIR_BIT_TILT 4
`define EIR_BIT_STEP 3
`define EIR_BIT_LATCH 7
`define EIR_BIT_PAGE_WRITE 6
`define EIR_BIT_PAGE_READ 5
`define EIR_BIT_BATCH_PROG 3
`define EIR_BIT_BATCH_FEAT 2
`define EIR_BIT_BATCH_LEARN 1
`define EIR_BIT_BATCH_STEP 0
`define EIR_BIT_ROUTE_MASTER 1

// Writable bits of each register; all others read zero
`define EIR_MASK_EMB 8'hb8
`define EIR_MASK_LOW_NIBBLE 8'h0f
`define EIR_MASK_PAGE_CTRL 8'he0
`define EIR_MASK_MAIN_CFG 8'h02

// Reset value of every register
`define EIR_RST_REG 8'h00

`endif

//--- hw/eir_pkg.sv
// Types shared by the embedded-function routing block
package eir_pkg;

    // Bus data-phase tracking
    typedef enum logic [1:0] {
        EIR_IDLE,
        EIR_WR_DATA,
        EIR_RD_WAIT
    } eir_phase_e;

    // Live event sources
    typedef struct packed {
        logic [3:0] emb;    // [3] long counter, [2] sig motion, [1] tilt, [0] step
        logic [7:0] prog;   // Programs eight to one
        logic [3:0] learn;  // Learning outputs four to one
    } eir_events_s;

    // FIFO batching enables
    typedef struct packed {
        logic batch_program_results;
        logic batch_learning_features;
        logic batch_learning_results;
        logic batch_step_counts;
    } eir_batch_s;

    // Advanced-features page access port
    typedef struct packed {
        logic wr;
        logic [3:0] sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } eir_page_req_s;

    // Software-visible registers
    typedef struct packed {
        logic [7:0] emb_event_second_interrupt_pin_route;
        logic [7:0] program_second_interrupt_pin_route;
        logic [7:0] learning_second_interrupt_pin_route;
        logic [7:0] page_access_control;
        logic [7:0] result_batching_enable;
        logic [7:0] page_select;
        logic [7:0] page_address;
        logic [7:0] ack_mask;
        logic [7:0] second_pin_main_config;
    } eir_regs_s;

    // Whole state of the top module
    typedef struct packed {
        eir_regs_s regs;
        eir_phase_e phase;
        logic [7:0] idx;
        logic hreadyout;
        logic [31:0] hrdata;
        logic page_wr;
        logic [7:0] page_wdata;
        logic second_interrupt_pin;
    } eir_state_s;

endpackage : eir_pkg

//--- hw/eir_flag_bank.sv
// Interrupt status flags of one source group, latched or live
`timescale 1ns/10ps

module eir_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_event,
    input wire logic i_latched,
    input wire logic i_read_clear,
    input wire logic [WIDTH-1:0] i_keep_mask,
    output logic [WIDTH-1:0] o_flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } eir_bank_s;

    eir_bank_s st;
    eir_bank_s next_st;
    logic [WIDTH-1:0] keep;

    // Latched: hold until read, set beats clear; live: follow events
    always_comb begin
        keep = i_read_clear ? i_keep_mask : {WIDTH{1'b1}};
        next_st = st;
        if (i_latched) begin
            next_st.flags = i_event | (st.flags & keep); // see R19
        end else begin
            next_st.flags = i_event; // see R20
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_flags = st.flags;

    // Event never lost, even during a clearing read
    a_event_sets_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see R19
        (i_event != '0) |=> ((o_flags & $past(i_event)) == $past(i_event)))
        else $error("event did not set its flag");

    // Latched flags hold when no read clears them
    a_latched_flag_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see R19
        (i_latched && !i_read_clear) |=> ((o_flags & $past(o_flags)) == $past(o_flags)))
        else $error("latched flag dropped without a read");

endmodule : eir_flag_bank

//--- hw/eir_route_top.sv
// Embedded-function interrupt routing, status flags and page access over AHB-Lite
`timescale 1ns/10ps
`include "eir_defines.svh"

// How it works
// R1 - Register 0Eh holds four routing enables for embedded events, reset zero.
// R2 - Second interrupt pin is OR of all flagged sources whose routing is set.
// R3 - Routing to the second pin only counts while the master routing bit is one.
// R4 - Host writes zero to reserved bits; the block stores them as zero.
// R5 - Register 0Fh holds eight program routing enables, reset zero.
// R6 - Register 11h low nibble routes learning outputs; upper nibble reserved.
// R7 - Register 12h flags long counter, motion, tilt, step; other bits zero.
// R8 - Register 13h flags the eight program events.
// R9 - Register 15h low nibble flags learning outputs; upper nibble reads zero.
// R10 - Page-control bit 7 selects latched flags; zero means live flags.
// R11 - Page writes reach the page only while page-write bit 6 is one.
// R12 - Page reads return page data only while page-read bit 5 is one.
// R13 - Page accesses go to the page chosen by the select field at 02h.
// R14 - Batching bit 3 enables program result batching, reset zero.
// R15 - Batching bit 2 enables learning filter and feature batching.
// R16 - Batching bit 1 enables learning result batching.
// R17 - Batching bit 0 enables step counter batching.
// R18 - Host puts the FIFO in continuous mode before enabling any batching.
// R19 - Latched flags clear on status read unless the acknowledge mask bit is set.
// R20 - Live mode lets flags and the pin follow the event directly.
module eir_route_top (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire eir_pkg::eir_events_s i_events,
    input wire logic [7:0] i_page_rdata,
    output eir_pkg::eir_page_req_s o_page,
    output eir_pkg::eir_batch_s o_batch,
    output logic o_second_interrupt_pin
);

    eir_pkg::eir_state_s st;
    eir_pkg::eir_state_s next_st;

    logic accept;
    logic [7:0] addr_idx;
    logic addr_in_map;
    logic latched;
    logic rd_emb;
    logic rd_prog;
    logic rd_learn;
    logic [7:0] emb_event_vec;
    logic [7:0] emb_flags;
    logic [7:0] prog_flags;
    logic [3:0] learn_flags;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic pin_sources;

    // Address phase decode; hsize is ignored, only whole words are used
    assign accept = i_hsel && i_htrans[1] && i_hready;
    assign addr_in_map = (i_haddr[31:10] == 22'h000000);
    assign addr_idx = addr_in_map ? i_haddr[9:2] : 8'hff;
    assign wbyte = i_hwdata[7:0];

    // Flag mode and read-clear strobes at the read capture edge
    assign latched = st.regs.page_access_control[`EIR_BIT_LATCH]; // see R10
    assign rd_emb = (st.phase == eir_pkg::EIR_RD_WAIT) && (st.idx == `EIR_IDX_EMB_FLAGS);
    assign rd_prog = (st.phase == eir_pkg::EIR_RD_WAIT) && (st.idx == `EIR_IDX_PROG_FLAGS);
    assign rd_learn = (st.phase == eir_pkg::EIR_RD_WAIT) && (st.idx == `EIR_IDX_LEARN_FLAGS);

    // Embedded events placed at their status bit positions
    assign emb_event_vec = {i_events.emb[3], 1'b0, i_events.emb[2:0], 3'b000}; // see R7

    // Embedded-event flags
    eir_flag_bank #(
        .WIDTH(8)
    ) u_emb_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_event(emb_event_vec),
        .i_latched(latched),
        .i_read_clear(rd_emb),
        .i_keep_mask(st.regs.ack_mask),
        .o_flags(emb_flags)
    );

    // Program event flags
    eir_flag_bank #(
        .WIDTH(8)
    ) u_prog_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_event(i_events.prog),
        .i_latched(latched),
        .i_read_clear(rd_prog),
        .i_keep_mask(st.regs.ack_mask),
        .o_flags(prog_flags)
    );

    // Learning output flags
    eir_flag_bank #(
        .WIDTH(4)
    ) u_learn_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_event(i_events.learn),
        .i_latched(latched),
        .i_read_clear(rd_learn),
        .i_keep_mask(st.regs.ack_mask[3:0]),
        .o_flags(learn_flags)
    );

    // OR of every flagged and routed source
    assign pin_sources = |(emb_flags & st.regs.emb_event_second_interrupt_pin_route) // see R1
        || |(prog_flags & st.regs.program_second_interrupt_pin_route) // see R5
        || |(learn_flags & st.regs.learning_second_interrupt_pin_route[3:0]); // see R6

    // Read data selection
    always_comb begin
        rd_byte = 8'h00;
        case (st.idx)
            `EIR_IDX_PAGE_SEL: rd_byte = st.regs.page_select;
            `EIR_IDX_PAGE_ADDR: rd_byte = st.regs.page_address;
            `EIR_IDX_PAGE_VALUE: begin
                if (st.regs.page_access_control[`EIR_BIT_PAGE_READ]) begin
                    rd_byte = i_page_rdata; // see R12
                end
            end
            `EIR_IDX_EMB_ROUTE: rd_byte = st.regs.emb_event_second_interrupt_pin_route;
            `EIR_IDX_PROG_ROUTE: rd_byte = st.regs.program_second_interrupt_pin_route;
            `EIR_IDX_LEARN_ROUTE: rd_byte = st.regs.learning_second_interrupt_pin_route;
            `EIR_IDX_EMB_FLAGS: rd_byte = emb_flags & `EIR_MASK_EMB; // see R7
            `EIR_IDX_PROG_FLAGS: rd_byte = prog_flags; // see R8
            `EIR_IDX_LEARN_FLAGS: rd_byte = {4'h0, learn_flags}; // see R9
            `EIR_IDX_PAGE_CTRL: rd_byte = st.regs.page_access_control;
            `EIR_IDX_BATCH: rd_byte = st.regs.result_batching_enable;
            `EIR_IDX_ACK_MASK: rd_byte = st.regs.ack_mask;
            `EIR_IDX_MAIN_CFG: rd_byte = st.regs.second_pin_main_config;
            default: rd_byte = 8'h00;
        endcase
    end

    // Next state: bus phases, register writes, page strobe, pin
    always_comb begin
        next_st = st;
        next_st.page_wr = 1'b0;
        // Close the current data phase
        case (st.phase)
            eir_pkg::EIR_WR_DATA: begin
                case (st.idx)
                    `EIR_IDX_PAGE_SEL: begin
                        next_st.regs.page_select = wbyte & `EIR_MASK_LOW_NIBBLE; // see R13
                    end
                    `EIR_IDX_PAGE_ADDR: next_st.regs.page_address = wbyte;
                    `EIR_IDX_PAGE_VALUE: begin
                        if (st.regs.page_access_control[`EIR_BIT_PAGE_WRITE]) begin
                            next_st.page_wr = 1'b1; // see R11
                            next_st.page_wdata = wbyte;
                        end
                    end
                    `EIR_IDX_EMB_ROUTE: begin
                        next_st.regs.emb_event_second_interrupt_pin_route = wbyte & `EIR_MASK_EMB; // see R4
                    end
                    `EIR_IDX_PROG_ROUTE: next_st.regs.program_second_interrupt_pin_route = wbyte; // see R5
                    `EIR_IDX_LEARN_ROUTE: begin
                        next_st.regs.learning_second_interrupt_pin_route = wbyte & `EIR_MASK_LOW_NIBBLE; // see R6
                    end
                    `EIR_IDX_PAGE_CTRL: begin
                        next_st.regs.page_access_control = wbyte & `EIR_MASK_PAGE_CTRL; // see R10
                    end
                    `EIR_IDX_BATCH: begin
                        next_st.regs.result_batching_enable = wbyte & `EIR_MASK_LOW_NIBBLE;
                    end
                    `EIR_IDX_ACK_MASK: next_st.regs.ack_mask = wbyte;
                    `EIR_IDX_MAIN_CFG: begin
                        next_st.regs.second_pin_main_config = wbyte & `EIR_MASK_MAIN_CFG;
                    end
                    default: next_st.regs = st.regs;
                endcase
                next_st.phase = eir_pkg::EIR_IDLE;
            end
            eir_pkg::EIR_RD_WAIT: begin
                next_st.hrdata = {24'h000000, rd_byte};
                next_st.hreadyout = 1'b1;
                next_st.phase = eir_pkg::EIR_IDLE;
            end
            eir_pkg::EIR_IDLE: next_st.phase = eir_pkg::EIR_IDLE;
            default: next_st.phase = eir_pkg::EIR_IDLE;
        endcase
        // Take a new address phase; reads get one wait state
        if (accept) begin
            next_st.idx = addr_idx;
            if (i_hwrite) begin
                next_st.phase = eir_pkg::EIR_WR_DATA;
            end else begin
                next_st.phase = eir_pkg::EIR_RD_WAIT;
                next_st.hreadyout = 1'b0;
            end
        end
        // Pin gated by the master routing bit
        next_st.second_interrupt_pin =
            st.regs.second_pin_main_config[`EIR_BIT_ROUTE_MASTER] && pin_sources; // see R2, R3
    end

    // State register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.hreadyout <= 1'b1;
            st.phase <= eir_pkg::EIR_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state or constant
    assign o_hrdata = st.hrdata;
    assign o_hreadyout = st.hreadyout;
    assign o_hresp = 1'b0;
    assign o_second_interrupt_pin = st.second_interrupt_pin;
    assign o_page.wr = st.page_wr;
    assign o_page.sel = st.regs.page_select[3:0]; // see R13
    assign o_page.addr = st.regs.page_address;
    assign o_page.wdata = st.page_wdata;

    // Batching enables
    assign o_batch.batch_program_results =
        st.regs.result_batching_enable[`EIR_BIT_BATCH_PROG]; // see R14
    assign o_batch.batch_learning_features =
        st.regs.result_batching_enable[`EIR_BIT_BATCH_FEAT]; // see R15
    assign o_batch.batch_learning_results =
        st.regs.result_batching_enable[`EIR_BIT_BATCH_LEARN]; // see R16
    assign o_batch.batch_step_counts =
        st.regs.result_batching_enable[`EIR_BIT_BATCH_STEP]; // see R17

    // Checks on the block's own outputs, registers and flags
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    logic master;
    assign master = st.regs.second_pin_main_config[`EIR_BIT_ROUTE_MASTER];

    a_pin_needs_master: assert property (!master |=> !o_second_interrupt_pin) // see R3
        else $error("pin raised with master routing off");

    a_pin_or_sources: assert property ( // see R2
        (master && pin_sources) |=> o_second_interrupt_pin)
        else $error("routed flag did not raise the pin");

    a_pin_quiet_no_source: assert property ( // see R2
        !pin_sources |=> !o_second_interrupt_pin)
        else $error("pin raised without a routed flag");

    a_route_reserved_zero: assert property ( // see R1
        (st.regs.emb_event_second_interrupt_pin_route & ~`EIR_MASK_EMB) == 8'h00)
        else $error("reserved routing bit stored");

    a_page_write_gate: assert property ( // see R11
        o_page.wr |-> $past(st.regs.page_access_control[`EIR_BIT_PAGE_WRITE]))
        else $error("page write while writes disabled");

    a_page_read_blocked: assert property ( // see R12
        (st.phase == eir_pkg::EIR_RD_WAIT && st.idx == `EIR_IDX_PAGE_VALUE
            && !st.regs.page_access_control[`EIR_BIT_PAGE_READ])
        |=> (o_hrdata == 32'h00000000) && o_hreadyout)
        else $error("page data returned while reads disabled");

    a_step_batch_write: assert property ( // see R17
        (st.phase == eir_pkg::EIR_WR_DATA && st.idx == `EIR_IDX_BATCH)
        |=> o_batch.batch_step_counts == $past(i_hwdata[0]))
        else $error("step batching bit not written");

    a_status_read_clear: assert property ( // see R19
        (latched && rd_prog && st.regs.ack_mask == 8'h00 && i_events.prog == 8'h00)
        |=> prog_flags == 8'h00)
        else $error("latched program flags not cleared by read");

    a_read_one_wait: assert property (
        (accept && !i_hwrite) |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read answer not after one wait state");

    c_pin_rises: cover property (!o_second_interrupt_pin ##1 o_second_interrupt_pin);
    c_page_write: cover property (o_page.wr);
    c_flag_cleared: cover property (rd_prog && latched && prog_flags != 8'h00);
    c_unmapped_read: cover property (accept && !i_hwrite && !addr_in_map);

endmodule : eir_route_top

//--- dv/eir_page_model.sv
// Advanced-features page memory behind the page port
`timescale 1ns/10ps

module eir_page_model (
    input wire logic i_ref_clk,
    input wire eir_pkg::eir_page_req_s i_page,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:4095];

    // Unwritten cells hold a pattern unlike the test values
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ 8'h3c;
        end
    end

    // Store one byte per write pulse in the selected page
    always @(posedge i_ref_clk) begin
        if (i_page.wr === 1'b1) begin
            mem[{i_page.sel, i_page.addr}] <= i_page.wdata;
        end
    end

    // Cell addressed by page select and page address
    assign o_rdata = mem[{i_page.sel, i_page.addr}];
endmodule : eir_page_model

//--- dv/test_eir_route_top.sv
// Self-checking bench of the routing block
`timescale 1ns/10ps
`include "eir_defines.svh"

module test_eir_route_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    eir_pkg::eir_events_s ev = '0;
    logic [7:0] page_rdata;
    eir_pkg::eir_page_req_s page;
    eir_pkg::eir_batch_s batch;
    logic pin;
    int err_total = 0;
    int check_count = 0;

    // Clock of 25 ns
    always #12.5 clk = ~clk;

    eir_route_top DUT (
        .i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_events(ev), .i_page_rdata(page_rdata), .o_page(page), .o_batch(batch),
        .o_second_interrupt_pin(pin)
    );

    eir_page_model PAGE (.i_ref_clk(clk), .i_page(page), .o_rdata(page_rdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // One AHB-Lite single word transfer, waits on hready
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        // Address phase held until hready is seen high; only the watchdog ends a hang
        @(posedge clk);
        while (hready !== 1'b1) begin
            @(posedge clk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hready !== 1'b1) begin
            @(posedge clk);
        end
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] v;
        bus(1'b1, idx, wd, v);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, idx, 8'h00, v);
        chk(v, exp);
    endtask : rdc

    // Let registered outputs land, then look mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic routes(input logic [7:0] e, input logic [7:0] p, input logic [7:0] l);
        wr(`EIR_IDX_EMB_ROUTE, e);
        wr(`EIR_IDX_PROG_ROUTE, p);
        wr(`EIR_IDX_LEARN_ROUTE, l);
    endtask : routes

    // Defaults after reset, unmapped index reads zero
    task automatic t_reset();
        logic [7:0] ix [9] = '{8'h0e, 8'h0f, 8'h11, 8'h12, 8'h13, 8'h15, 8'h17, 8'h18, 8'h3f};
        foreach (ix[i]) rdc(ix[i], 32'h0);
        settle(0);
        chk(32'(batch), 32'h0);
        chk(32'(pin), 32'h0);
        chk(32'(hresp), 32'h0);
    endtask : t_reset

    // Writable bits read back, status ignores writes, batch bits
    task automatic t_masks();
        logic [7:0] ix [5] = '{8'h0e, 8'h0f, 8'h11, 8'h17, 8'h18};
        logic [7:0] mk [5] = '{8'hb8, 8'hff, 8'h0f, 8'he0, 8'h0f};
        foreach (ix[i]) begin
            wr(ix[i], mk[i]);
            rdc(ix[i], {24'h0, mk[i]});
            wr(ix[i], 8'h00);
        end
        wr(`EIR_IDX_EMB_FLAGS, 8'hff);
        rdc(`EIR_IDX_EMB_FLAGS, 32'h0);
        // FIFO continuous mode is the host's job outside this block
        for (int k = 0; k < 4; k++) begin
            wr(`EIR_IDX_BATCH, 8'h01 << k);
            settle(1);
            chk(32'(batch), 32'h1 << k);
        end
        wr(`EIR_IDX_BATCH, 8'h00);
    endtask : t_masks

    // Each source alone, routed, masked by master bit, unrouted
    task automatic t_route();
        logic [15:0] one;
        logic [7:0] e;
        logic [7:0] pos [4] = '{8'h08, 8'h10, 8'h20, 8'h80};
        for (int i = 0; i < 16; i++) begin
            one = 16'h1 << i;
            e = (i >= 12) ? pos[i - 12] : 8'h00;
            @(posedge clk);
            ev <= one;
            routes(e, one[11:4], {4'h0, one[3:0]});
            wr(`EIR_IDX_MAIN_CFG, 8'h00);
            settle(3);
            chk(32'(pin), 32'h0);
            wr(`EIR_IDX_MAIN_CFG, 8'h02);
            settle(3);
            chk(32'(pin), 32'h1);
            if (i >= 12) rdc(`EIR_IDX_EMB_FLAGS, {24'h0, e});
            else if (i >= 4) rdc(`EIR_IDX_PROG_FLAGS, {24'h0, one[11:4]});
            else rdc(`EIR_IDX_LEARN_FLAGS, {24'h0, 4'h0, one[3:0]});
            routes(8'hb8 & ~e, ~one[11:4], {4'h0, ~one[3:0]});
            settle(3);
            chk(32'(pin), 32'h0);
        end
    endtask : t_route

    task automatic pulse_prog1();
        @(posedge clk);
        ev <= 16'h0010;
        @(posedge clk);
        ev <= '0;
    endtask : pulse_prog1

    // Live versus latched flags, read clear and its mask
    task automatic t_latch();
        @(posedge clk);
        ev <= '0;
        routes(8'h00, 8'h01, 8'h00);
        pulse_prog1();
        settle(3);
        chk(32'(pin), 32'h0);
        rdc(`EIR_IDX_PROG_FLAGS, 32'h0);
        // Held event shows live, then drops with it
        ev <= 16'h0010;
        rdc(`EIR_IDX_PROG_FLAGS, 32'h1);
        chk(32'(pin), 32'h1);
        ev <= '0;
        rdc(`EIR_IDX_PROG_FLAGS, 32'h0);
        wr(`EIR_IDX_PAGE_CTRL, 8'h80);
        pulse_prog1();
        settle(3);
        chk(32'(pin), 32'h1);
        rdc(`EIR_IDX_PROG_FLAGS, 32'h1);
        rdc(`EIR_IDX_PROG_FLAGS, 32'h0);
        settle(3);
        chk(32'(pin), 32'h0);
        wr(`EIR_IDX_ACK_MASK, 8'h01);
        pulse_prog1();
        rdc(`EIR_IDX_PROG_FLAGS, 32'h1);
        rdc(`EIR_IDX_PROG_FLAGS, 32'h1);
        wr(`EIR_IDX_ACK_MASK, 8'h00);
        rdc(`EIR_IDX_PROG_FLAGS, 32'h1);
        rdc(`EIR_IDX_PROG_FLAGS, 32'h0);
        wr(`EIR_IDX_PAGE_CTRL, 8'h00);
    endtask : t_latch

    // Page access gated by enables, aimed by page select
    task automatic t_page();
        wr(`EIR_IDX_PAGE_SEL, 8'h05);
        wr(`EIR_IDX_PAGE_ADDR, 8'h33);
        wr(`EIR_IDX_PAGE_VALUE, 8'ha5);
        rdc(`EIR_IDX_PAGE_VALUE, 32'h0);
        wr(`EIR_IDX_PAGE_CTRL, 8'h20);
        rdc(`EIR_IDX_PAGE_VALUE, 32'h0f);
        wr(`EIR_IDX_PAGE_CTRL, 8'h60);
        wr(`EIR_IDX_PAGE_VALUE, 8'ha5);
        wr(`EIR_IDX_PAGE_SEL, 8'h06);
        wr(`EIR_IDX_PAGE_VALUE, 8'h5a);
        chk(32'(page.sel), 32'h6);
        wr(`EIR_IDX_PAGE_SEL, 8'h05);
        rdc(`EIR_IDX_PAGE_VALUE, 32'ha5);
        wr(`EIR_IDX_PAGE_SEL, 8'h06);
        rdc(`EIR_IDX_PAGE_VALUE, 32'h5a);
        wr(`EIR_IDX_PAGE_CTRL, 8'h00);
    endtask : t_page

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_masks();
        t_route();
        t_latch();
        t_page();
        finish_test();
    end

    // Watchdog against a hung transfer
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule : test_eir_route_top
